// ==== dv/flash_timing_security_regs_properties.sv ====
module flash_timing_security_regs_properties (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        commandActive,
	input wire logic        commandCompleteFlag,
	input wire logic        initDone,
	input wire logic [5:0]  divideRatioField,
	input wire logic        dividerLockBit,
	input wire logic [2:0]  commandIndexField,
	input wire logic        backdoorUnsecure,
	input wire logic        deviceSecured
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic wrOk;
	assign wrOk = psel && penable && pwrite && pstrb[0];
	////////////////////////////////////////////////////////////////
	a_div_write_takes: assert property (wrOk && paddr == 12'h0400 && !dividerLockBit
		|=> divideRatioField == $past(pwdata[5:0])) else $error("divide field not written");
	a_lock_sets: assert property (wrOk && paddr == 12'h0400 && pwdata[6]
		|=> dividerLockBit) else $error("lock bit not set");
	a_lock_sticky: assert property (dividerLockBit |=> dividerLockBit)
		else $error("lock bit cleared without reset");
	a_field_frozen: assert property (dividerLockBit |=> $stable(divideRatioField))
		else $error("locked divide field changed");
	a_index_write: assert property (wrOk && paddr == 12'h0408
		|=> commandIndexField == $past(pwdata[2:0])) else $error("index not written");
	a_busy_flag: assert property (commandActive |-> !commandCompleteFlag)
		else $error("complete flag high during command");
	a_init_seq: assert property ($rose(rst_b) |-> !initDone[*4] ##[1:2] initDone)
		else $error("init sequence length wrong");
	a_backdoor_unsec: assert property (backdoorUnsecure && initDone |=> !deviceSecured)
		else $error("backdoor did not unsecure");
endmodule : flash_timing_security_regs_properties

bind flash_timing_security_regs flash_timing_security_regs_properties props_inst (.*);

// ==== dv/test_flash_timing_security_regs.sv ====
module test_flash_timing_security_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [7:0]  nvSecurityByte;
	logic        nvDoubleFault, commandActive, backdoorUnsecure, commandCompleteFlag;
	logic [2:0]  commandIndexField;
	logic [5:0]  divideRatioField;
	logic        dividerLockBit, keyAccessEnabled, deviceSecured, initDone;
	int          n_errors = 0;
	int          n_checks = 0;

	flash_timing_security_regs flash_timing_security_regs_inst (.*);

	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask : chk

	// one setup and one access phase; idle edge after so the next call never
	// reassigns psel in the same time step
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(a, 1'b1, d, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
		logic [31:0] q;
		logic e;
		apb(a, 1'b0, 8'h00, q, e);
		chk(q, x);
		chk(e, xe);
	endtask : rd

	task automatic do_reset(input logic [7:0] nv, input logic f);
		rst_b <= 0; nvSecurityByte <= nv; nvDoubleFault <= f;
		repeat (20) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
	endtask : do_reset

	task automatic wait_init;
		for (int i = 0; i < 20 && initDone !== 1'b1; i++) @(posedge clk);
		chk(initDone, 1'b1);
	endtask : wait_init
	////////////////////////////////////////////////////////////////
	task automatic t_divider;
		wr(12'h0400, 8'h13);
		chk(commandCompleteFlag, 1'b0);
		wait_init();
		rd(12'h0400, 32'h0000_0093);
		wr(12'h0400, 8'h45);
		rd(12'h0400, 32'h0000_00C5);
		chk(dividerLockBit, 1'b1);
		wr(12'h0400, 8'h0A);
		rd(12'h0400, 32'h0000_00C5);
		chk(divideRatioField, 6'h05);
	endtask : t_divider

	task automatic t_regs;
		rd(12'h0404, 32'h0000_00BE);
		chk(keyAccessEnabled, 1'b1);
		chk(deviceSecured, 1'b0);
		wr(12'h0404, 8'h00);
		rd(12'h0404, 32'h0000_00BE);
		wr(12'h0408, 8'hFF);
		rd(12'h0408, 32'h0000_0007);
		chk(commandIndexField, 3'h7);
		pstrb <= 4'h0;
		wr(12'h0408, 8'h02);
		pstrb <= 4'h1;
		rd(12'h0408, 32'h0000_0007);
		wr(12'h040C, 8'hFF);
		rd(12'h040C, 32'h0000_0000);
		rd(12'h0410, 32'h0000_0000, 1'b1);
		commandActive <= 1;
		@(posedge clk);
		chk(commandCompleteFlag, 1'b0);
		commandActive <= 0;
		@(posedge clk);
		chk(commandCompleteFlag, 1'b1);
	endtask : t_regs

	task automatic t_backdoor;
		wait_init();
		rd(12'h0404, 32'h0000_007D);
		chk(deviceSecured, 1'b1);
		chk(keyAccessEnabled, 1'b0);
		backdoorUnsecure <= 1;
		@(posedge clk);
		backdoorUnsecure <= 0;
		rd(12'h0404, 32'h0000_007E);
		chk(deviceSecured, 1'b0);
	endtask : t_backdoor

	task automatic t_fault;
		wait_init();
		rd(12'h0404, 32'h0000_00FF);
		chk(keyAccessEnabled, 1'b0);
		rd(12'h0400, 32'h0000_0000);
		wr(12'h0400, 8'h07);
		rd(12'h0400, 32'h0000_0087);
	endtask : t_fault

	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'h1;
		rst_b = 0; nvSecurityByte = 0; nvDoubleFault = 0;
		commandActive = 0; backdoorUnsecure = 0;
		do_reset(8'hBE, 1'b0);
		t_divider();
		t_regs();
		do_reset(8'h7D, 1'b0);
		t_backdoor();
		do_reset(8'h7D, 1'b1);
		t_fault();
		conclude();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule : test_flash_timing_security_regs

// ==== rtl/clock_divider_reg.sv ====
`include "flash_regs_consts.svh"

module clock_divider_reg (
	input  wire logic   clk,
	input  wire logic   rst_b,
	reg_access_if.slave acc
);
	logic       loaded_ff;
	logic       lock_ff;
	logic [5:0] divide_ff;
	logic       wrOk;

	assign wrOk = acc.wrEn && acc.writesOpen; // [RULE_08]

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_ff <= 1'b0; // [RULE_20]
		end else if (wrOk) begin
			loaded_ff <= 1'b1; // [RULE_03]
		end
	end

	// lock is one-way; only reset clears it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_ff <= 1'b0; // [RULE_20]
		end else if (wrOk && acc.wrData[`BIT_DIV_LOCK]) begin
			lock_ff <= 1'b1; // [RULE_02] [RULE_04]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divide_ff <= `DIV_RESET_VALUE;
		end else if (wrOk && !lock_ff) begin
			divide_ff <= acc.wrData[`DIV_FIELD_MSB:0]; // [RULE_02] [RULE_05]
		end
	end

	// top bit write data ignored
	assign acc.rdData = {loaded_ff, lock_ff, divide_ff}; // [RULE_01]
endmodule : clock_divider_reg

// ==== rtl/command_index_reg.sv ====
`include "flash_regs_consts.svh"

module command_index_reg (
	input  wire logic   clk,
	input  wire logic   rst_b,
	reg_access_if.slave acc
);
	logic [2:0] index_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			index_ff <= `CMD_INDEX_RESET;
		end else if (acc.wrEn && acc.writesOpen) begin
			index_ff <= acc.wrData[`CMD_INDEX_MSB:0]; // [RULE_16]
		end
	end

	assign acc.rdData = {5'h00, index_ff}; // [RULE_16]
endmodule : command_index_reg

// ==== rtl/flash_timing_security_regs.sv ====
// Design decision made here: register access over APB.
`include "flash_regs_consts.svh"

// Functional notes
// [RULE_01] divider reads fully; loaded bit ignores writes
// [RULE_02] lock bit write-once high; freezes divide field
// [RULE_03] loaded bit set by first write
// [RULE_04] only reset clears lock bit
// [RULE_05] divide field yields 1 MHz tick
// [RULE_06] software picks divide by clock band
// [RULE_07] software avoids divider writes mid-command
// [RULE_08] divider writable during reset sequence
// [RULE_09] security register read-only
// [RULE_10] security loaded from nonvolatile byte
// [RULE_11] double-bit fault sets all security bits
// [RULE_12] key access enabled only at 10
// [RULE_13] unsecured only when security field 10
// [RULE_14] backdoor unsecure forces field to 10
// [RULE_15] reserved nonvolatile bits left erased
// [RULE_16] index bits 2:0 rw, rest zero
// [RULE_17] index selects command word
// [RULE_18] factory test register reads zero
// [RULE_19] complete flag low during command
// [RULE_20] loaded and lock reset to zero
module flash_timing_security_regs (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  nvSecurityByte,
	input  wire logic        nvDoubleFault,
	input  wire logic        commandActive,
	input  wire logic        backdoorUnsecure,
	output logic             commandCompleteFlag,
	output logic [2:0]       commandIndexField,
	output logic [5:0]       divideRatioField,
	output logic             dividerLockBit,
	output logic             keyAccessEnabled,
	output logic             deviceSecured,
	output logic             initDone
);
	flash_regs_pkg::init_state_t initState_ff;
	flash_regs_pkg::init_state_t nxt_initState;
	logic [3:0]                  fetchCnt_ff;
	logic                        fetchLast;
	logic                        loadCycle;
	logic                        inReset;
	flash_regs_pkg::reg_byte_t   nvByte_ff;
	logic                        nvFault_ff;
	flash_regs_pkg::reg_byte_t   nvLoadValue;
	logic [1:0]                  keyEnable_ff;
	logic [3:0]                  reservedNv_ff;
	logic [1:0]                  securityField_ff;
	flash_regs_pkg::reg_byte_t   securityByte;
	logic                        apbSetup;
	logic                        apbAccess;
	logic                        apbReadSetup;
	logic                        apbWrite;
	logic                        hitDiv;
	logic                        hitSec;
	logic                        hitIdx;
	logic                        hitTst;
	logic                        mapped;
	logic                        writesOpen;
	logic [31:0]                 divReadWord;
	logic [31:0]                 secReadWord;
	logic [31:0]                 idxReadWord;
	logic [31:0]                 tstReadWord;
	logic [31:0]                 nxt_prdata;
	logic [31:0]                 prdata_ff;

	reg_access_if divBus ();
	reg_access_if idxBus ();

	////////////////////////////////////////////////////////////////////////////
	// reset sequence: fetch nonvolatile byte, then release command engine

	assign fetchLast = fetchCnt_ff == 4'(`NV_FETCH_CYCLES - 1);
	assign loadCycle = initState_ff == flash_regs_pkg::INIT_LOAD;

	always_comb begin
		nxt_initState = initState_ff;
		unique case (initState_ff)
			flash_regs_pkg::INIT_FETCH: begin
				if (fetchLast) begin
					nxt_initState = flash_regs_pkg::INIT_LOAD;
				end
			end
			flash_regs_pkg::INIT_LOAD: begin
				nxt_initState = flash_regs_pkg::INIT_DONE;
			end
			flash_regs_pkg::INIT_DONE: begin
				nxt_initState = flash_regs_pkg::INIT_DONE;
			end
			// code 11 is never entered; fall back to a fresh fetch
			default: begin
				nxt_initState = flash_regs_pkg::INIT_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			initState_ff <= flash_regs_pkg::INIT_FETCH;
		end else begin
			initState_ff <= nxt_initState;
		end
	end

	// counter parks past its end value once the fetch is over
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fetchCnt_ff <= 4'h0;
		end else if (initState_ff == flash_regs_pkg::INIT_FETCH) begin
			fetchCnt_ff <= fetchCnt_ff + 4'h1;
		end
	end

	assign inReset  = initState_ff != flash_regs_pkg::INIT_DONE;
	assign initDone = !inReset;

	// complete flag low while resetting or a command runs
	assign commandCompleteFlag = !inReset && !commandActive; // [RULE_19]

	////////////////////////////////////////////////////////////////////////////
	// nonvolatile fetch result

	// sampled on the last fetch cycle, applied in the load cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nvByte_ff <= `SEC_ALL_ONES;
		end else if (fetchLast) begin
			nvByte_ff <= nvSecurityByte; // [RULE_10]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nvFault_ff <= 1'b0;
		end else if (fetchLast) begin
			nvFault_ff <= nvDoubleFault; // [RULE_11]
		end
	end

	// a failed fetch must not open the part, so the fault wins
	always_comb begin
		nvLoadValue = nvByte_ff; // [RULE_10]
		if (nvFault_ff) begin
			nvLoadValue = `SEC_ALL_ONES; // [RULE_11]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// security state

	// reset value secured, keys off, until the fetch lands
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			keyEnable_ff <= `KEY_FIELD_RESET;
		end else if (loadCycle) begin
			keyEnable_ff <= nvLoadValue[`KEY_FIELD_MSB:`KEY_FIELD_LSB]; // [RULE_10]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reservedNv_ff <= `RNV_FIELD_RESET;
		end else if (loadCycle) begin
			reservedNv_ff <= nvLoadValue[`RNV_FIELD_MSB:`RNV_FIELD_LSB]; // [RULE_10]
		end
	end

	// backdoor unsecure cannot override the load cycle itself
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			securityField_ff <= `SEC_FIELD_RESET;
		end else if (loadCycle) begin
			securityField_ff <= nvLoadValue[`SEC_FIELD_MSB:0]; // [RULE_10]
		end else if (backdoorUnsecure) begin
			securityField_ff <= `SEC_UNSECURED_CODE; // [RULE_14]
		end
	end

	assign securityByte = {keyEnable_ff, reservedNv_ff, securityField_ff}; // [RULE_09]

	assign keyAccessEnabled = keyEnable_ff == `KEY_ENABLED_CODE; // [RULE_12]
	assign deviceSecured    = securityField_ff != `SEC_UNSECURED_CODE; // [RULE_13]

	////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states

	assign apbSetup     = psel && !penable;
	assign apbAccess    = psel && penable;
	assign apbReadSetup = apbSetup && !pwrite;
	// a write without the low lane strobe carries no byte for these registers
	assign apbWrite     = apbAccess && pwrite && pstrb[0];

	// full compare on the byte address; any other offset is unmapped
	always_comb begin
		hitDiv = 1'b0;
		hitSec = 1'b0;
		hitIdx = 1'b0;
		hitTst = 1'b0;
		unique case (paddr)
			`ADDR_CLOCK_DIVIDER: begin
				hitDiv = 1'b1;
			end
			`ADDR_SECURITY_STATE: begin
				hitSec = 1'b1;
			end
			`ADDR_COMMAND_INDEX: begin
				hitIdx = 1'b1;
			end
			`ADDR_FACTORY_TEST: begin
				hitTst = 1'b1;
			end
			default: begin
			end
		endcase
	end

	assign mapped = hitDiv || hitSec || hitIdx || hitTst;

	// every access completes in one cycle, so no wait states
	assign pready  = 1'b1;
	assign pslverr = apbAccess && !mapped;

	// command engine state is not consulted: keeping out mid-command writes
	// is left to software, and the reset sequence must stay writable
	assign writesOpen = 1'b1; // [RULE_08]

	// writes to the security and test registers fall on the floor
	assign divBus.wrEn       = apbWrite && hitDiv; // [RULE_09] [RULE_18]
	assign divBus.wrData     = pwdata[7:0];
	assign divBus.writesOpen = writesOpen; // [RULE_08]
	assign idxBus.wrEn       = apbWrite && hitIdx;
	assign idxBus.wrData     = pwdata[7:0];
	assign idxBus.writesOpen = writesOpen;

	// divider and index registers live in their own modules
	clock_divider_reg clock_divider_reg_inst (
		.clk   (clk),
		.rst_b (rst_b),
		.acc   (divBus.slave)
	);

	command_index_reg command_index_reg_inst (
		.clk   (clk),
		.rst_b (rst_b),
		.acc   (idxBus.slave)
	);

	assign divReadWord = {24'h00_0000, divBus.rdData}; // [RULE_01]
	assign secReadWord = {24'h00_0000, securityByte}; // [RULE_09]
	assign idxReadWord = {24'h00_0000, idxBus.rdData}; // [RULE_16]
	assign tstReadWord = 32'h0000_0000; // [RULE_18]

	// unmapped offsets read as zero too
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (1'b1)
			hitDiv: begin
				nxt_prdata = divReadWord;
			end
			hitSec: begin
				nxt_prdata = secReadWord;
			end
			hitIdx: begin
				nxt_prdata = idxReadWord;
			end
			hitTst: begin
				nxt_prdata = tstReadWord; // [RULE_18]
			end
			default: begin
			end
		endcase
	end

	// read data captured in setup so it is a flop in the access phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apbReadSetup) begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// outputs toward flash core

	// the core sees the live register values, no extra pipeline stage
	assign commandIndexField = idxBus.rdData[2:0]; // [RULE_17]
	assign divideRatioField  = divBus.rdData[5:0]; // [RULE_05]
	assign dividerLockBit    = divBus.rdData[`BIT_DIV_LOCK];
endmodule : flash_timing_security_regs

// ==== shared/flash_regs_consts.svh ====
`ifndef FLASH_REGS_CONSTS_SVH
`define FLASH_REGS_CONSTS_SVH

// register indices; the byte address is four times the index
`define IDX_CLOCK_DIVIDER     12'h0100
`define IDX_SECURITY_STATE    12'h0101
`define IDX_COMMAND_INDEX     12'h0102
`define IDX_FACTORY_TEST      12'h0103

`define ADDR_CLOCK_DIVIDER    12'h0400
`define ADDR_SECURITY_STATE   12'h0404
`define ADDR_COMMAND_INDEX    12'h0408
`define ADDR_FACTORY_TEST     12'h040C

`define BIT_DIV_LOADED        7
`define BIT_DIV_LOCK          6
`define DIV_FIELD_MSB         5
`define CMD_INDEX_MSB         2
`define KEY_FIELD_MSB         7
`define KEY_FIELD_LSB         6
`define RNV_FIELD_MSB         5
`define RNV_FIELD_LSB         2
`define SEC_FIELD_MSB         1

`define SEC_UNSECURED_CODE    2'h2
`define KEY_ENABLED_CODE      2'h2
`define SEC_ALL_ONES          8'hFF
`define KEY_FIELD_RESET       2'h3
`define RNV_FIELD_RESET       4'hF
`define SEC_FIELD_RESET       2'h3
`define DIV_RESET_VALUE       6'h00
`define CMD_INDEX_RESET       3'h0

// time for the nonvolatile fetch after reset release
`define NV_FETCH_TIME_NS      200
`define CLK_PERIOD_NS         50
`define NV_FETCH_CYCLES       ((`NV_FETCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== shared/flash_regs_pkg.sv ====
package flash_regs_pkg;
	typedef enum logic [1:0] {
		INIT_FETCH = 2'b00,
		INIT_LOAD  = 2'b01,
		INIT_DONE  = 2'b10
	} init_state_t;

	typedef logic [7:0] reg_byte_t;
endpackage : flash_regs_pkg

// ==== shared/reg_access_if.sv ====
interface reg_access_if;
	logic       wrEn;
	logic [7:0] wrData;
	logic       writesOpen;
	logic [7:0] rdData;

	modport master (
		output wrEn,
		output wrData,
		output writesOpen,
		input  rdData
	);
	modport slave (
		input  wrEn,
		input  wrData,
		input  writesOpen,
		output rdData
	);
endinterface : reg_access_if
